/* File: rtl/clk_sel_defines.svh */
// Offsets, field positions, reset values and timing counts
`ifndef CLK_SEL_DEFINES_SVH
`define CLK_SEL_DEFINES_SVH
`define OSC_CTL_ADDR      4'h0
`define CLK_DIV_ADDR      4'h1
`define FAIL_STAT_ADDR    4'h2
`define OPT_MODE_ADDR     4'h3
`define UNLOCK_KEY1       8'he7
`define UNLOCK_KEY2       8'h18
`define OSC_CTL_RESET     8'ha0
`define FLP_DIV_RESET     8'h08
`define DIV_RESET         8'h00
`define BIT_INT_EN        7
`define BIT_XTL_EN        6
`define BIT_WDT_EN        5
`define BIT_POF_EN        4
`define BIT_WDF_EN        3
`define BIT_FLP_EN        2
`define SEL_INT           2'h0
`define SEL_XTL           2'h1
`define SEL_WDT           2'h2
`define WDT_FAIL_CYCLES   14'h1f40
`define PRI_FAIL_HZ       1000
`define CORE_HZ           10000000
`define PRI_FAIL_CYCLES   (`CORE_HZ / `PRI_FAIL_HZ)
`define FLASH_SLOW_HZ     10000000
`endif

/* File: rtl/clk_sel_pkg.sv */
// Types for the system clock select block
package clk_sel_pkg;
  typedef enum logic [1:0] {
    lock_idle,
    lock_key1,
    lock_open
  } lock_state_t;
  typedef enum logic [1:0] {
    osc_rc,
    osc_xtal_min,
    osc_xtal_med,
    osc_xtal_max
  } osc_mode_t;
endpackage

/* File: rtl/system_clock_select_control.sv */
// System clock source select, divider, unlock and failure detection
//
// Local design decisions: the register offsets and strobed register access.
`include "clk_sel_defines.svh"
module system_clock_select_control (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [1:0] osc_mode_option,
  input  wire logic       flash_low_power_option,
  input  wire logic       int_osc_clk,
  input  wire logic       xtal_osc_clk,
  input  wire logic       wdt_osc_clk,
  output logic            sys_clk_en,
  output logic      [1:0] sys_clk_source,
  output logic            flash_power_down,
  output logic            sys_exception,
  output logic            int_osc_enable,
  output logic            xtal_osc_enable,
  output logic            wdt_osc_enable
);
  // Oscillator inputs are sampled levels from other domains
  logic [2:0] osc_s1_q, osc_s2_q, osc_s3_q;
  logic [1:0] opt_mode_s1_q, opt_mode_s2_q;
  logic       flash_low_power_option_s1_q, flash_low_power_option_s2_q;
  logic [2:0] edge_rise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_s1_q      <= 3'h0;
      osc_s2_q      <= 3'h0;
      osc_s3_q      <= 3'h0;
      opt_mode_s1_q <= 2'h0;
      opt_mode_s2_q <= 2'h0;
    end else begin
      osc_s1_q      <= {wdt_osc_clk, xtal_osc_clk, int_osc_clk};
      osc_s2_q      <= osc_s1_q;
      osc_s3_q      <= osc_s2_q;
      opt_mode_s1_q <= osc_mode_option;
      opt_mode_s2_q <= opt_mode_s1_q;
    end
  end

  // Option bit keeps sampling during reset
  // So the strap sees the pin, not a reset value
  always_ff @(posedge core_clk) begin
    flash_low_power_option_s1_q <= flash_low_power_option;
    flash_low_power_option_s2_q <= flash_low_power_option_s1_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_edge
      assign edge_rise[gi] = osc_s2_q[gi] & ~osc_s3_q[gi];
    end
  endgenerate

  // Register state
  logic [7:0]                 osc_ctl_q, osc_ctl_d;
  logic [7:0]                 div_q, div_d;
  clk_sel_pkg::lock_state_t   lock_q, lock_d;
  logic                       strap_q, strap_d;
  logic                       pri_fail_q, pri_fail_d;
  logic                       wdt_fail_q, wdt_fail_d;
  logic                       exc_q, exc_d;
  logic [7:0]                 rdata_q, rdata_d;
  logic [13:0]                wdt_cnt_q, wdt_cnt_d;
  logic [13:0]                pri_cnt_q, pri_cnt_d;
  logic                       rc_half_q, rc_half_d;
  logic [7:0]                 dcnt_q, dcnt_d;
  logic                       clk_en_q, clk_en_d;
  logic                       fpd_q, fpd_d;
  logic [1:0]                 src_q, src_d;
  logic [1:0]                 sel_eff;
  logic                       src_tick;
  logic                       ctl_wr;

  assign ctl_wr = reg_wr && (reg_addr == `OSC_CTL_ADDR);

  always_comb begin
    osc_ctl_d  = osc_ctl_q;
    div_d      = div_q;
    lock_d     = lock_q;
    strap_d    = 1'b1;
    pri_fail_d = pri_fail_q;
    wdt_fail_d = wdt_fail_q;
    exc_d      = 1'b0;
    rdata_d    = 8'h00;
    wdt_cnt_d  = wdt_cnt_q;
    pri_cnt_d  = pri_cnt_q;
    // Low power option caught once after reset release
    if (!strap_q) begin
      if (!flash_low_power_option_s2_q) begin
        osc_ctl_d[`BIT_FLP_EN] = 1'b1;
        div_d                  = `FLP_DIV_RESET;
      end
    end
    if (ctl_wr) begin
      case (lock_q)
        clk_sel_pkg::lock_idle:
          lock_d = (reg_wdata == `UNLOCK_KEY1) ? clk_sel_pkg::lock_key1
                                               : clk_sel_pkg::lock_idle;
        clk_sel_pkg::lock_key1: begin
          if (reg_wdata == `UNLOCK_KEY2) begin
            lock_d = clk_sel_pkg::lock_open;
          end else if (reg_wdata == `UNLOCK_KEY1) begin
            lock_d = clk_sel_pkg::lock_key1;
          end else begin
            lock_d = clk_sel_pkg::lock_idle;
          end
        end
        clk_sel_pkg::lock_open: begin
          osc_ctl_d = reg_wdata;
          lock_d    = clk_sel_pkg::lock_idle;
        end
        default: lock_d = clk_sel_pkg::lock_idle;
      endcase
    end
    if (reg_wr && reg_addr == `CLK_DIV_ADDR) begin
      div_d = reg_wdata;
    end
    if (edge_rise[2] || !osc_ctl_q[`BIT_WDT_EN]) begin
      wdt_cnt_d = 14'h0;
    end else if (wdt_cnt_q != `WDT_FAIL_CYCLES) begin
      wdt_cnt_d = wdt_cnt_q + 14'h1;
    end
    if (wdt_cnt_q == `WDT_FAIL_CYCLES - 14'h1 && !wdt_fail_q) begin
      wdt_fail_d = 1'b1;
      if (osc_ctl_q[`BIT_WDF_EN]) begin
        exc_d = 1'b1;
        osc_ctl_d[`BIT_WDF_EN] = 1'b0;
      end
    end
    if (src_tick || wdt_fail_q) begin
      pri_cnt_d = 14'h0;
    end else if (pri_cnt_q != 14'(`PRI_FAIL_CYCLES)) begin
      pri_cnt_d = pri_cnt_q + 14'h1;
    end
    // switch to watchdog clock
    // Saturated count still trips once detection is enabled
    if (pri_cnt_q >= 14'(`PRI_FAIL_CYCLES - 1) && osc_ctl_q[`BIT_POF_EN]
        && osc_ctl_q[1:0] != `SEL_WDT) begin
      pri_fail_d = 1'b1;
      exc_d      = 1'b1;
      osc_ctl_d[`BIT_POF_EN] = 1'b0;
      osc_ctl_d[`BIT_WDT_EN] = 1'b1;
    end
    if (reg_wr && reg_addr == `FAIL_STAT_ADDR && reg_wdata[0]) begin
      pri_fail_d = pri_fail_d & pri_fail_q & ~exc_d ? 1'b0 : pri_fail_d;
    end
    if (reg_rd) begin
      case (reg_addr)
        `OSC_CTL_ADDR:   rdata_d = osc_ctl_q;
        `CLK_DIV_ADDR:   rdata_d = div_q;
        `FAIL_STAT_ADDR: rdata_d = {5'h0, lock_q == clk_sel_pkg::lock_open,
                                    wdt_fail_q, pri_fail_q};
        `OPT_MODE_ADDR:  rdata_d = {6'h0, opt_mode_s2_q};
        default:         rdata_d = 8'h00;
      endcase
    end
    src_d = pri_fail_d ? `SEL_WDT : osc_ctl_d[1:0];
  end

  // source select, forced to watchdog after a primary failure
  assign sel_eff = pri_fail_q ? `SEL_WDT : osc_ctl_q[1:0];
  always_comb begin
    case (sel_eff)
      `SEL_XTL: src_tick = edge_rise[1];
      `SEL_WDT: src_tick = edge_rise[2];
      default:  src_tick = edge_rise[0];
    endcase
  end

  // Clock enable path: RC halving, then programmable divide
  always_comb begin
    rc_half_d = rc_half_q;
    dcnt_d    = dcnt_q;
    clk_en_d  = 1'b0;
    if (src_tick) begin
      // Crystal source halved in RC option mode, otherwise undivided
      if (sel_eff == `SEL_XTL && opt_mode_s2_q == 2'(clk_sel_pkg::osc_rc))
      begin
        rc_half_d = ~rc_half_q;
      end else begin
        rc_half_d = 1'b1;
      end
      if (rc_half_d) begin
        if (dcnt_q + 8'h1 >= div_q) begin
          dcnt_d   = 8'h0;
          clk_en_d = 1'b1;
        end else begin
          dcnt_d = dcnt_q + 8'h1;
        end
      end
    end
    // flash idles between enables in low power mode
    fpd_d = osc_ctl_q[`BIT_FLP_EN] && !clk_en_d;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osc_ctl_q  <= `OSC_CTL_RESET;
      div_q      <= `DIV_RESET;
      lock_q     <= clk_sel_pkg::lock_idle;
      strap_q    <= 1'b0;
      pri_fail_q <= 1'b0;
      wdt_fail_q <= 1'b0;
      exc_q      <= 1'b0;
      rdata_q    <= 8'h00;
      wdt_cnt_q  <= 14'h0;
      pri_cnt_q  <= 14'h0;
      rc_half_q  <= 1'b0;
      dcnt_q     <= 8'h00;
      clk_en_q   <= 1'b0;
      fpd_q      <= 1'b0;
      src_q      <= `SEL_INT;
    end else begin
      osc_ctl_q  <= osc_ctl_d;
      div_q      <= div_d;
      lock_q     <= lock_d;
      strap_q    <= strap_d;
      pri_fail_q <= pri_fail_d;
      wdt_fail_q <= wdt_fail_d;
      exc_q      <= exc_d;
      rdata_q    <= rdata_d;
      wdt_cnt_q  <= wdt_cnt_d;
      pri_cnt_q  <= pri_cnt_d;
      rc_half_q  <= rc_half_d;
      dcnt_q     <= dcnt_d;
      clk_en_q   <= clk_en_d;
      fpd_q      <= fpd_d;
      src_q      <= src_d;
    end
  end

  assign reg_rdata        = rdata_q;
  assign sys_clk_en       = clk_en_q;
  assign flash_power_down = fpd_q;
  assign sys_exception    = exc_q;
  assign int_osc_enable   = osc_ctl_q[`BIT_INT_EN];
  assign xtal_osc_enable  = osc_ctl_q[`BIT_XTL_EN];
  assign wdt_osc_enable   = osc_ctl_q[`BIT_WDT_EN];
  assign sys_clk_source   = src_q;

  // Assertions
  a_write_needs_unlock: assert property (
    @(posedge core_clk) disable iff (rst)
    ctl_wr && lock_q != clk_sel_pkg::lock_open && !exc_d && strap_q
    |=> $stable(osc_ctl_q)) else $error("locked write changed control");
  a_unlock_relocks: assert property (
    @(posedge core_clk) disable iff (rst)
    ctl_wr && lock_q == clk_sel_pkg::lock_open
    |=> lock_q == clk_sel_pkg::lock_idle && osc_ctl_q == $past(reg_wdata))
    else $error("open write not applied");
  a_key_order: assert property (
    @(posedge core_clk) disable iff (rst)
    ctl_wr && lock_q == clk_sel_pkg::lock_key1 && reg_wdata == `UNLOCK_KEY2
    |=> lock_q == clk_sel_pkg::lock_open) else $error("unlock missed");
  a_other_access: assert property (
    @(posedge core_clk) disable iff (rst)
    !ctl_wr |=> lock_q == $past(lock_q)) else $error("lock disturbed");
  a_reset_source: assert property (
    @(posedge core_clk) disable iff (rst)
    !strap_q |-> sys_clk_source == `SEL_INT)
    else $error("reset source wrong");
  a_strap_defaults: assert property (
    @(posedge core_clk) disable iff (rst)
    !strap_q && !flash_low_power_option_s2_q
    |=> div_q == `FLP_DIV_RESET && osc_ctl_q[`BIT_FLP_EN])
    else $error("low power defaults missing");
  a_pri_fail_switch: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(pri_fail_q) |-> sys_clk_source == `SEL_WDT && exc_q
    && !osc_ctl_q[`BIT_POF_EN]) else $error("no failover");
  a_wdt_fail_count: assert property (
    @(posedge core_clk) disable iff (rst)
    $rose(wdt_fail_q) |-> $past(wdt_cnt_q) == `WDT_FAIL_CYCLES - 14'h1)
    else $error("watchdog fail count");
  a_flash_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    flash_power_down |-> !sys_clk_en && $past(osc_ctl_q[`BIT_FLP_EN]))
    else $error("flash down while clocking");
endmodule // system_clock_select_control

/* File: sim/tb.sv */
// Self-checking bench for the system clock select block
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
  n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk, rst, reg_wr, reg_rd, flash_low_power_option;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, cyc;
  logic [1:0] osc_mode_option, sys_clk_source;
  logic       int_osc_clk, xtal_osc_clk, wdt_osc_clk, sys_clk_en;
  logic       flash_power_down, sys_exception, int_run, xtal_run, wdt_run;
  logic       int_osc_enable, xtal_osc_enable, wdt_osc_enable;
  int         n_mismatch, num_checks, n, p, b;

  system_clock_select_control i_system_clock_select_control (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .osc_mode_option(osc_mode_option),
    .flash_low_power_option(flash_low_power_option),
    .int_osc_clk(int_osc_clk), .xtal_osc_clk(xtal_osc_clk),
    .wdt_osc_clk(wdt_osc_clk), .sys_clk_en(sys_clk_en),
    .sys_clk_source(sys_clk_source), .flash_power_down(flash_power_down),
    .sys_exception(sys_exception), .int_osc_enable(int_osc_enable),
    .xtal_osc_enable(xtal_osc_enable), .wdt_osc_enable(wdt_osc_enable));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Oscillator stand-ins: int and wdt period 4, xtal period 8
  initial begin
    cyc = 8'h00;
    int_osc_clk = 1'b0;
    xtal_osc_clk = 1'b0;
    wdt_osc_clk = 1'b0;
    forever begin
      @(posedge core_clk);
      cyc <= cyc + 8'h01;
      int_osc_clk <= int_run & cyc[1];
      xtal_osc_clk <= xtal_run & cyc[2];
      wdt_osc_clk <= wdt_run & cyc[1];
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rst_dut(input logic opt);
    flash_low_power_option <= opt;
    rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask

  task automatic unl(input logic [7:0] d);
    wr(4'h0, 8'he7);
    wr(4'h0, 8'h18);
    wr(4'h0, d);
  endtask

  // Counts ticks, flash power-down cycles and overlaps over 160 cycles
  task automatic ticks();
    n = 0; p = 0; b = 0;
    repeat (160) begin
      @(negedge core_clk);
      if (sys_clk_en === 1'b1) n++;
      if (flash_power_down === 1'b1) p++;
      if (sys_clk_en === 1'b1 && flash_power_down === 1'b1) b++;
    end
  endtask

  task automatic wait_exc(input int lim);
    for (int i = 0; i < lim; i++) begin
      @(negedge core_clk);
      if (sys_exception === 1'b1) return;
    end
    n_mismatch++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask

  initial begin
    rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0;
    reg_wdata = 8'h00; osc_mode_option = 2'h3;
    flash_low_power_option = 1'b1;
    int_run = 1'b1; xtal_run = 1'b1; wdt_run = 1'b1;
    n_mismatch = 0; num_checks = 0;
    rst_dut(1'b1);
    rd(4'h0, v); `CHK(v, 8'ha0)
    `CHK(sys_clk_source, 2'h0)
    wr(4'h0, 8'h61);
    rd(4'h0, v); `CHK(v, 8'ha0)
    wr(4'h0, 8'he7);
    rd(4'h1, v);
    wr(4'h3, 8'h00);
    wr(4'h0, 8'h18);
    rd(4'h2, v); `CHK(v & 8'h04, 8'h04)
    wr(4'h0, 8'h61);
    rd(4'h0, v); `CHK(v, 8'h61)
    `CHK(sys_clk_source, 2'h1)
    `CHK(xtal_osc_enable, 1'b1)
    `CHK(int_osc_enable, 1'b0)
    wr(4'h0, 8'ha0);
    rd(4'h0, v); `CHK(v, 8'h61)
    wr(4'h0, 8'h18);
    wr(4'h0, 8'he7);
    wr(4'h0, 8'h00);
    rd(4'h0, v); `CHK(v, 8'h61)
    ticks(); `CHK(n inside {[19:21]}, 1'b1)
    osc_mode_option <= 2'h0;
    repeat (4) @(posedge core_clk);
    ticks(); `CHK(n inside {[9:11]}, 1'b1)
    osc_mode_option <= 2'h3;
    wr(4'h1, 8'h02);
    repeat (4) @(posedge core_clk);
    ticks(); `CHK(n inside {[9:11]}, 1'b1)
    for (int m = 0; m < 4; m++) begin
      osc_mode_option <= m[1:0];
      repeat (4) @(posedge core_clk);
      rd(4'h3, v); `CHK(v[1:0], m[1:0])
    end
    wr(4'h0, 8'he7);
    rst_dut(1'b1);
    wr(4'h0, 8'h18);
    wr(4'h0, 8'h61);
    rd(4'h0, v); `CHK(v, 8'ha0)
    unl(8'ha2);
    rd(4'h0, v); `CHK(sys_clk_source, 2'h2)
    // Primary source stops, then its failure detection is turned on
    int_run <= 1'b0;
    unl(8'h90);
    wait_exc(12000);
    rd(4'h0, v); `CHK(v & 8'h30, 8'h20)
    `CHK(wdt_osc_enable, 1'b1)
    `CHK(sys_clk_source, 2'h2)
    rd(4'h2, v); `CHK(v & 8'h01, 8'h01)
    wr(4'h2, 8'h01);
    rd(4'h2, v); `CHK(v & 8'h01, 8'h00)
    int_run <= 1'b1;
    rst_dut(1'b1);
    unl(8'ha8);
    wdt_run <= 1'b0;
    wait_exc(9000);
    rd(4'h2, v); `CHK(v & 8'h02, 8'h02)
    `CHK(sys_clk_source, 2'h0)
    wdt_run <= 1'b1;
    rst_dut(1'b0);
    rd(4'h0, v); `CHK(v, 8'ha4)
    rd(4'h1, v); `CHK(v, 8'h08)
    ticks(); `CHK(b, 0)
    `CHK(p > 100, 1'b1)
    // Crystal enabled first, selected after it settles
    unl(8'he4);
    @(negedge core_clk);
    `CHK(xtal_osc_enable, 1'b1)
    `CHK(sys_clk_source, 2'h0)
    repeat (20) @(posedge core_clk);
    unl(8'he5);
    @(negedge core_clk);
    `CHK(sys_clk_source, 2'h1)
    print_verdict();
  end
endmodule // tb
